//--- rtl/epm_regs.sv
// Purpose: power and input mode registers behind the serial control port byte layer
// Assumes: the serial engine hands over whole bytes with one-cycle strobes
// Notes: the first byte written after access_start, before any read, is the register pointer
`timescale 1ns/1ps
module epm_regs (
   input wire logic clock, // 25 MHz system clock
   input wire logic nrst, // async reset, active low
   input wire logic access_start, // pulse: start of a port access
   input wire logic access_stop, // pulse: end of a port access
   input wire logic wr_stb, // pulse: host byte on wr_byte
   input wire logic [7:0] wr_byte, // host byte
   input wire logic rd_stb, // pulse: host wants a byte
   output logic ack, // pulse: byte accepted
   output logic nack, // pulse: byte refused, port idle
   output logic rd_valid, // pulse: rd_byte is valid
   output logic [7:0] rd_byte, // byte returned to host
   output logic [5:0] dac_power_on, // bit n powers converter n+1
   output logic pll_on, // internal pll running
   output logic oversample_on, // oversampling running
   output logic sleep_active, // low-power sleep in force
   output logic ddr_luma_rising, // double-rate: luma on rising edge
   output logic ddr_active, // double-rate capture in use
   output logic [2:0] input_format, // selected input format
   output logic format_reserved, // reserved edge or format code held
   output logic bus_swap, // swapped bus mapping in force
   output logic [7:0] output_mode // output mode control contents
);
   epm_pkg::epm_state_e state, next_state;
   logic [7:0] power_control, next_power_control;
   logic [7:0] input_mode_select, next_input_mode_select;
   logic [7:0] output_mode_control, next_output_mode_control;
   logic next_ack, next_nack, next_rd_valid;
   logic [7:0] next_rd_byte;
   logic ptr_load, ptr_incr, ptr_ok;
   logic [7:0] ptr;
   logic [5:0] next_dac;
   logic next_pll, next_os, next_sleep, next_luma_rise, next_ddr, next_resv, next_swap;
   logic [2:0] fmt;
   logic [1:0] edge_sel;

   // read mux shared by the read path; out of range returns the last register
   function automatic logic [7:0] reg_at(input logic [7:0] p, input logic [7:0] r0,
                                          input logic [7:0] r1, input logic [7:0] r2);
      logic [7:0] v;
      v = r2;
      case (p)
         epm_pkg::ADDR_POWER: v = r0;
         epm_pkg::ADDR_MODE_SEL: v = r1;
         default: v = r2;
      endcase
      return v;
   endfunction

   epm_pointer #(
      .LAST(epm_pkg::ADDR_LAST)
   ) u_ptr (
      .clock(clock),
      .nrst(nrst),
      .load(ptr_load),
      .load_value(wr_byte),
      .incr(ptr_incr),
      .register_pointer_bits(ptr),
      .in_range(ptr_ok)
   );

   // port sequencing and register writes; sleep does not gate this path
   always_comb begin
      next_state = state;
      next_power_control = power_control;
      next_input_mode_select = input_mode_select;
      next_output_mode_control = output_mode_control;
      next_ack = 1'b0;
      next_nack = 1'b0;
      next_rd_valid = 1'b0;
      next_rd_byte = rd_byte;
      ptr_load = 1'b0;
      ptr_incr = 1'b0;
      if (access_start) begin
         next_state = epm_pkg::EPM_PTR;
      end else if (access_stop) begin
         next_state = epm_pkg::EPM_IDLE;
      end else begin
         case (state)
            epm_pkg::EPM_IDLE: begin
               next_state = epm_pkg::EPM_IDLE;
            end
            epm_pkg::EPM_PTR: begin
               if (wr_stb) begin
                  ptr_load = 1'b1;
                  if (wr_byte <= epm_pkg::ADDR_LAST) begin
                     next_ack = 1'b1;
                     next_state = epm_pkg::EPM_DATA;
                  end else begin
                     next_nack = 1'b1;
                     next_state = epm_pkg::EPM_IDLE;
                  end
               end else if (rd_stb) begin
                  // read access reuses the pointer left by the previous access
                  next_rd_valid = 1'b1;
                  next_rd_byte = reg_at(ptr, power_control, input_mode_select,
                                        output_mode_control);
                  ptr_incr = 1'b1;
                  next_state = epm_pkg::EPM_DATA;
               end
            end
            epm_pkg::EPM_DATA: begin
               if (wr_stb) begin
                  if (ptr_ok) begin
                     case (ptr)
                        epm_pkg::ADDR_POWER: next_power_control = wr_byte;
                        epm_pkg::ADDR_MODE_SEL: next_input_mode_select = wr_byte;
                        default: next_output_mode_control = wr_byte;
                     endcase
                     next_ack = 1'b1;
                     ptr_incr = 1'b1;
                  end else begin
                     // past the last register: byte dropped, port idle
                     next_nack = 1'b1;
                     next_state = epm_pkg::EPM_IDLE;
                  end
               end else if (rd_stb) begin
                  next_rd_valid = 1'b1;
                  next_rd_byte = reg_at(ptr, power_control, input_mode_select,
                                        output_mode_control);
                  ptr_incr = 1'b1;
               end
            end
            default: begin
               next_state = epm_pkg::EPM_IDLE;
            end
         endcase
      end
   end

   // port and register flops
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state <= epm_pkg::EPM_IDLE;
         power_control <= epm_pkg::RST_POWER;
         input_mode_select <= epm_pkg::RST_MODE_SEL;
         output_mode_control <= epm_pkg::RST_OUT_MODE;
         ack <= 1'b0;
         nack <= 1'b0;
         rd_valid <= 1'b0;
         rd_byte <= 8'h00;
      end else begin
         state <= next_state;
         power_control <= next_power_control;
         input_mode_select <= next_input_mode_select;
         output_mode_control <= next_output_mode_control;
         ack <= next_ack;
         nack <= next_nack;
         rd_valid <= next_rd_valid;
         rd_byte <= next_rd_byte;
      end
   end

   // decode of the control fields into the analog and datapath controls
   always_comb begin
      fmt = input_mode_select[epm_pkg::FMT_MSB:epm_pkg::FMT_LSB];
      edge_sel = input_mode_select[epm_pkg::EDGE_MSB:epm_pkg::EDGE_LSB];
      next_sleep = power_control[epm_pkg::SLEEP_BIT];
      next_dac = {power_control[epm_pkg::DAC6_BIT], power_control[epm_pkg::DAC5_BIT],
                  power_control[epm_pkg::DAC4_BIT], power_control[epm_pkg::DAC3_BIT],
                  power_control[epm_pkg::DAC2_BIT], power_control[epm_pkg::DAC1_BIT]}
                 & {6{~next_sleep}};
      next_pll = ~power_control[epm_pkg::PLL_OFF_BIT] & ~next_sleep;
      next_os = ~power_control[epm_pkg::PLL_OFF_BIT] & ~next_sleep;
      next_ddr = (fmt == epm_pkg::FMT_DOUBLE) || (fmt == epm_pkg::FMT_SD_DOUBLE);
      next_luma_rise = next_ddr && (edge_sel == epm_pkg::EDGE_LUMA_RISE);
      // flag undefined codes rather than guess their effect
      next_resv = (fmt > epm_pkg::FMT_SD_DOUBLE && fmt != epm_pkg::FMT_ED_54)
                  || (next_ddr && edge_sel != epm_pkg::EDGE_CHROMA_RISE
                      && edge_sel != epm_pkg::EDGE_LUMA_RISE);
      // swap only when standard definition is present
      next_swap = input_mode_select[epm_pkg::SWAP_BIT]
                  && (fmt == epm_pkg::FMT_SD || fmt == epm_pkg::FMT_SD_SINGLE
                      || fmt == epm_pkg::FMT_SD_DOUBLE);
   end

   // registered controls, one cycle behind the register contents
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         dac_power_on <= 6'h00;
         pll_on <= 1'b0;
         oversample_on <= 1'b0;
         sleep_active <= 1'b0;
         ddr_luma_rising <= 1'b0;
         ddr_active <= 1'b0;
         input_format <= 3'h0;
         format_reserved <= 1'b0;
         bus_swap <= 1'b0;
         output_mode <= 8'h00;
      end else begin
         dac_power_on <= next_dac;
         pll_on <= next_pll;
         oversample_on <= next_os;
         sleep_active <= next_sleep;
         ddr_luma_rising <= next_luma_rise;
         ddr_active <= next_ddr;
         input_format <= fmt;
         format_reserved <= next_resv;
         bus_swap <= next_swap;
         output_mode <= output_mode_control;
      end
   end
endmodule

//--- pkg/epm_pkg.sv
// Purpose: shared constants for the encoder power and mode register front end
// Assumes: byte-wide serial control port, registers at consecutive pointer values
// Notes: reset values and field positions live here only
package epm_pkg;
   // register pointer values
   localparam logic [7:0] ADDR_POWER = 8'h00;
   localparam logic [7:0] ADDR_MODE_SEL = 8'h01;
   localparam logic [7:0] ADDR_OUT_MODE = 8'h02;
   localparam logic [7:0] ADDR_LAST = 8'h02;
   // reset values
   localparam logic [7:0] RST_POWER = 8'h12;
   localparam logic [7:0] RST_MODE_SEL = 8'h00;
   localparam logic [7:0] RST_OUT_MODE = 8'h20;
   localparam logic [7:0] RST_POINTER = 8'h00;
   // power register fields
   localparam int SLEEP_BIT = 0;
   localparam int PLL_OFF_BIT = 1;
   localparam int DAC3_BIT = 2;
   localparam int DAC2_BIT = 3;
   localparam int DAC1_BIT = 4;
   localparam int DAC6_BIT = 5;
   localparam int DAC5_BIT = 6;
   localparam int DAC4_BIT = 7;
   // mode select fields
   localparam int EDGE_LSB = 1;
   localparam int EDGE_MSB = 2;
   localparam int FMT_LSB = 4;
   localparam int FMT_MSB = 6;
   localparam int SWAP_BIT = 7;
   localparam logic [1:0] EDGE_CHROMA_RISE = 2'h0;
   localparam logic [1:0] EDGE_LUMA_RISE = 2'h3;
   // input format codes
   localparam logic [2:0] FMT_SD = 3'h0;
   localparam logic [2:0] FMT_SINGLE = 3'h1;
   localparam logic [2:0] FMT_DOUBLE = 3'h2;
   localparam logic [2:0] FMT_SD_SINGLE = 3'h3;
   localparam logic [2:0] FMT_SD_DOUBLE = 3'h4;
   localparam logic [2:0] FMT_ED_54 = 3'h7;
   // port state, gray along idle -> pointer -> data
   typedef enum logic [1:0] {
      EPM_IDLE = 2'h0,
      EPM_PTR = 2'h1,
      EPM_DATA = 2'h3
   } epm_state_e;
endpackage

//--- rtl/epm_pointer.sv
// Purpose: write-only register pointer with load and auto-increment
// Assumes: load and increment never asserted together
// Notes: increment saturates at the all-ones value so it never wraps onto a valid register
`timescale 1ns/1ps
module epm_pointer #(
   parameter logic [7:0] LAST = epm_pkg::ADDR_LAST
) (
   input wire logic clock, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic load, // load pointer from host byte
   input wire logic [7:0] load_value, // byte to load
   input wire logic incr, // step to next register
   output logic [7:0] register_pointer_bits, // current pointer
   output logic in_range // pointer names a register
);
   logic [7:0] next_ptr;

   // next pointer value
   always_comb begin
      next_ptr = register_pointer_bits;
      if (load) begin
         next_ptr = load_value;
      end else if (incr && register_pointer_bits != 8'hFF) begin
         next_ptr = register_pointer_bits + 8'h01;
      end
   end

   // pointer flop
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         register_pointer_bits <= epm_pkg::RST_POINTER;
      end else begin
         register_pointer_bits <= next_ptr;
      end
   end

   assign in_range = (register_pointer_bits <= LAST);
endmodule

//--- dv/epm_regs_chk.sv
// Purpose: port checker for the power and mode register front end
// Assumes: one clock domain, async active-low reset
// Notes: bound to epm_regs below the module
`timescale 1ns/1ps
module epm_chk (
   input wire logic clock, // system clock
   input wire logic nrst, // reset, active low
   input wire logic access_start, // access begins
   input wire logic access_stop, // access ends
   input wire logic wr_stb, // host byte strobe
   input wire logic [7:0] wr_byte, // host byte
   input wire logic rd_stb, // read strobe
   input wire logic ack, // byte taken
   input wire logic nack, // byte refused
   input wire logic rd_valid, // read data valid
   input wire logic [5:0] dac_power_on, // converter power
   input wire logic pll_on, // pll running
   input wire logic oversample_on, // oversampling
   input wire logic sleep_active, // sleep
   input wire logic ddr_luma_rising, // luma rising
   input wire logic ddr_active, // double rate
   input wire logic [2:0] input_format, // format
   input wire logic format_reserved, // reserved code
   input wire logic bus_swap // swap
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   logic await_ptr;
   // pointer phase: from a start until the first strobe or stop, gaps allowed
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         await_ptr <= 1'b0;
      end else if (access_start) begin
         await_ptr <= 1'b1;
      end else if (access_stop || wr_stb || rd_stb) begin
         await_ptr <= 1'b0;
      end
   end
   // the pointer byte is the first write after a start, when no read comes before it
   property p_ptr_ack;
      await_ptr && wr_stb && !access_start && !access_stop && wr_byte <= 8'h02
      |=> ack && !nack;
   endproperty
   a_ptr_ack: assert property (p_ptr_ack) else $error("pointer byte not taken");
   property p_bad_ptr;
      await_ptr && wr_stb && !access_start && !access_stop && wr_byte > 8'h02
      |=> nack && !ack;
   endproperty
   a_bad_ptr: assert property (p_bad_ptr) else $error("bad pointer not refused");
   property p_rd_cause;
      rd_valid |-> $past(rd_stb) && !$past(wr_stb) && !ack;
   endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("read data without request");
   property p_ans_cause;
      (ack || nack) |-> $past(wr_stb) && !(ack && nack);
   endproperty
   a_ans_cause: assert property (p_ans_cause) else $error("answer without byte");
   property p_sleep;
      sleep_active |-> dac_power_on == 6'h00 && !pll_on;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep left power on");
   property p_pll;
      oversample_on == pll_on;
   endproperty
   a_pll: assert property (p_pll) else $error("pll and oversampling differ");
   property p_edge;
      ddr_luma_rising |-> ddr_active && !format_reserved;
   endproperty
   a_edge: assert property (p_edge) else $error("edge choice outside double rate");
   property p_fmt;
      ddr_active == (input_format == 3'h2 || input_format == 3'h4)
      && (!(input_format inside {3'h5, 3'h6}) || format_reserved);
   endproperty
   a_fmt: assert property (p_fmt) else $error("format decode wrong");
   property p_swap;
      bus_swap |-> input_format inside {3'h0, 3'h3, 3'h4};
   endproperty
   a_swap: assert property (p_swap) else $error("swap outside sd");
   c_sleep: cover property (sleep_active && rd_valid);
   c_luma: cover property (ddr_luma_rising);
   c_nack: cover property (nack);
endmodule
bind epm_regs epm_chk u_chk (.clock, .nrst, .access_start, .access_stop, .wr_stb, .wr_byte,
   .rd_stb, .ack, .nack, .rd_valid, .dac_power_on, .pll_on, .oversample_on, .sleep_active,
   .ddr_luma_rising, .ddr_active, .input_format, .format_reserved, .bus_swap);

//--- dv/epm_host.sv
// Purpose: host model driving byte strobes into the register port
// Assumes: answers come one cycle after the strobe edge
// Notes: gap adds idle cycles so the port sees slow hosts too
`timescale 1ns/1ps
module epm_host (
   input wire logic clock, // system clock
   input wire logic ack, // byte taken
   input wire logic nack, // byte refused
   input wire logic rd_valid, // read data valid
   input wire logic [7:0] rd_byte, // read data
   output logic access_start, // access begins
   output logic access_stop, // access ends
   output logic wr_stb, // host byte strobe
   output logic [7:0] wr_byte, // host byte
   output logic rd_stb // read strobe
);
   int gap = 0;
   initial begin
      {access_start, access_stop, wr_stb, rd_stb, wr_byte} = 12'h000;
   end
   task automatic pulse(input int k, input logic [7:0] b, output logic [2:0] r,
      output logic [7:0] q);
      repeat (gap) @(negedge clock);
      @(negedge clock);
      case (k)
         0: access_start = 1'b1;
         1: access_stop = 1'b1;
         2: {wr_stb, wr_byte} = {1'b1, b};
         default: rd_stb = 1'b1;
      endcase
      @(negedge clock);
      // answers stand for one cycle only, so take them before they fall
      r = {ack, nack, rd_valid};
      q = rd_byte;
      {access_start, access_stop, wr_stb, rd_stb} = 4'h0;
      wr_byte = ~b; // lane released: do not leave the old byte showing
   endtask
endmodule

//--- dv/encoder_power_mode_regs_tb.sv
// Purpose: self-checking bench for the register front end
// Assumes: host model drives strobes at the falling edge
// Notes: mreg and ptr model the registers and the pointer
`timescale 1ns/1ps
module encoder_power_mode_regs_tb;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic access_start, access_stop, wr_stb, rd_stb, ack, nack, rd_valid, pll_on;
   logic oversample_on, sleep_active, ddr_luma_rising, ddr_active, format_reserved, bus_swap;
   logic [7:0] wr_byte, rd_byte, output_mode, rb, d, p, m;
   logic [5:0] dac_power_on;
   logic [2:0] input_format, r;
   logic [7:0] mreg [3];
   int ptr, n_fail, checks_done, cyc, seed;
   always #20 clock = ~clock;
   epm_host host (.clock, .ack, .nack, .rd_valid, .rd_byte, .access_start, .access_stop,
      .wr_stb, .wr_byte, .rd_stb);
   epm_regs uut (.clock, .nrst, .access_start, .access_stop, .wr_stb, .wr_byte, .rd_stb,
      .ack, .nack, .rd_valid, .rd_byte, .dac_power_on, .pll_on, .oversample_on,
      .sleep_active, .ddr_luma_rising, .ddr_active, .input_format, .format_reserved,
      .bus_swap, .output_mode);
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_resp(input logic [2:0] got, input logic [2:0] exp);
      chk_val({5'h00, got}, {5'h00, exp});
   endtask
   task automatic hs(input int k, input logic [7:0] b);
      host.pulse(k, b, r, rb);
   endtask
   task automatic open(input logic [7:0] a);
      hs(0, 8'h00);
      hs(2, a);
      ptr = a;
      chk_resp(r, a <= 8'h02 ? 3'h4 : 3'h2);
   endtask
   task automatic wbyte(input logic [7:0] b);
      hs(2, b);
      if (ptr <= 2) mreg[ptr] = b;
      chk_resp(r, ptr <= 2 ? 3'h4 : 3'h2);
      if (ptr <= 2) ptr++;
   endtask
   task automatic rbyte;
      hs(3, 8'h00);
      chk_resp(r, 3'h1);
      chk_val(rb, mreg[ptr > 2 ? 2 : ptr]);
      ptr = ptr == 255 ? 255 : ptr + 1;
   endtask
   task automatic chk_dec;
      p = mreg[0];
      m = mreg[1];
      chk_val({2'h0, dac_power_on},
         p[0] ? 8'h00 : {2'h0, p[5], p[6], p[7], p[2], p[3], p[4]});
      chk_val({5'h00, pll_on, oversample_on, sleep_active},
         {5'h00, {2{~p[1] & ~p[0]}}, p[0]});
      chk_val({3'h0, format_reserved, bus_swap, input_format},
         {4'h0, m[7] & (m[6:4] inside {3'h0, 3'h3, 3'h4}), m[6:4]});
      chk_val({6'h00, ddr_active, ddr_luma_rising},
         {6'h00, m[6:4] inside {3'h2, 3'h4},
         m[6:4] inside {3'h2, 3'h4} && m[2:1] == 2'h3});
      chk_val(output_mode, mreg[2]);
   endtask
   // hang guard, the whole run needs well under this
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      seed = $urandom(32'hEEB5DA42);
      mreg = '{8'h12, 8'h00, 8'h20};
      ptr = 0;
      repeat (3) @(negedge clock);
      nrst = 1'b1;
      // decode flops take the reset register values on the first edge after release
      @(negedge clock);
      chk_dec();
      hs(0, 8'h00);
      repeat (4) rbyte(); // reset values, then past the top
      hs(1, 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         host.gap = $urandom_range(2);
         d = 8'($urandom_range(255)) & 8'hFE | 8'(i % 2);
         open(8'h00);
         wbyte(d);
         hs(0, 8'h00);
         rbyte();
         hs(1, 8'h00);
         chk_dec();
      end
      $display("test power register done");
      for (int f = 0; f < 8; f++) begin
         for (int e = 0; e < 4; e += 3) begin
            if (f == 5 || f == 6) continue;
            d = {1'($urandom_range(1)), 3'(f), 1'b0, 2'(e), 1'b0};
            open(8'h01);
            wbyte(d);
            wbyte(8'($urandom_range(63)) << 2);
            hs(1, 8'h00);
            chk_dec();
         end
      end
      $display("test mode select done");
      open(8'h00);
      for (int i = 0; i < 4; i++) begin
         // mode select: bits 6 and 3 clear, edge 00 or 11
         d = 8'($urandom_range(255)) & 8'hFC;
         if (i == 1) d = (d & 8'hB5) | {6'h00, d[2], 1'b0};
         wbyte(d);
      end
      chk_dec();
      open(8'h05);
      hs(2, 8'hAA);
      chk_resp(r, 3'h0);
      hs(0, 8'h00);
      rbyte();
      hs(1, 8'h00);
      chk_dec();
      $display("test overflow and bad pointer done");
      conclude();
   end
endmodule
